// file: design/iap_defines.svh
// Constants for the indirect address pointer unit
`ifndef IAP_DEFINES_SVH
`define IAP_DEFINES_SVH
`define IAP_PTR_RESET 12'h000
`define IAP_PTR_ONE 12'h001
`define IAP_HI_USED_MSB 3
`define IAP_OP_PLAIN 3'h0
`define IAP_OP_DEC_AFTER 3'h1
`define IAP_OP_INC_AFTER 3'h2
`define IAP_OP_INC_BEFORE 3'h3
`define IAP_OP_OFFSET 3'h4
`define IAP_VLOC_BASE 12'hfdb
`define IAP_VLOC_LAST 12'hfef
`endif

// file: design/iap_pkg.sv
// Types for the indirect address pointer unit
package iap_pkg;
	typedef logic [11:0] iap_addr_t;
	typedef enum logic [2:0] {
		IAP_PLAIN = 3'b000,
		IAP_DEC_AFTER = 3'b001,
		IAP_INC_AFTER = 3'b010,
		IAP_INC_BEFORE = 3'b011,
		IAP_OFFSET = 3'b100
	} iap_mode_e;
	typedef enum logic [1:0] {
		IAP_ST_IDLE = 2'b00,
		IAP_ST_ACCESS = 2'b01
	} iap_state_e;
endpackage : iap_pkg

// file: design/iap_ptr_if.sv
// Pointer update path between the main unit and one pointer pair
`timescale 1ns/1ps
interface iap_ptr_if;
	logic write_hi;
	logic write_lo;
	logic [7:0] wdata;
	logic step_inc;
	logic step_dec;
	logic [11:0] value;
	modport ctrl (output write_hi, output write_lo, output wdata, output step_inc,
		output step_dec, input value);
	modport pair (input write_hi, input write_lo, input wdata, input step_inc,
		input step_dec, output value);
endinterface : iap_ptr_if

// file: design/iap_ptr_pair.sv
// One 12-bit pointer pair with byte writes and step by one
`timescale 1ns/1ps
`include "iap_defines.svh"
module iap_ptr_pair (
	// Clock and reset
	input wire logic clk_sys_in,
	input wire logic sys_rst_in,
	// Control
	iap_ptr_if.pair ptr_if
);
	logic [11:0] ptr;
	logic [11:0] next_ptr;

	always_comb
	begin
		next_ptr = ptr;
		if (ptr_if.write_hi)
			next_ptr = {ptr_if.wdata[`IAP_HI_USED_MSB:0], ptr[7:0]};
		else if (ptr_if.write_lo)
			next_ptr = {ptr[11:8], ptr_if.wdata};
		else if (ptr_if.step_inc)
			next_ptr = ptr + `IAP_PTR_ONE;
		else if (ptr_if.step_dec)
			next_ptr = ptr - `IAP_PTR_ONE;
	end

	always_ff @(posedge clk_sys_in)
	begin
		if (sys_rst_in)
			ptr <= `IAP_PTR_RESET;
		else
			ptr <= next_ptr;
	end

	assign ptr_if.value = ptr;

	property p_step_up;
		@(posedge clk_sys_in) disable iff (sys_rst_in)
		(ptr_if.step_inc && !ptr_if.write_hi && !ptr_if.write_lo)
			|=> ptr == $past(ptr) + `IAP_PTR_ONE;
	endproperty
	a_step_up: assert property (p_step_up) else $error("pointer increment wrong");
endmodule : iap_ptr_pair

// file: design/iap_unit.sv
// Indirect data-memory addressing unit with three pointer pairs
`timescale 1ns/1ps
`include "iap_defines.svh"
module iap_unit (
	// Clock and reset
	input wire logic clk_sys_in,
	input wire logic sys_rst_in,
	// Operand request from the core
	input wire logic op_valid_in,
	input wire logic [1:0] op_set_in,
	input wire logic [2:0] op_mode_in,
	input wire logic op_write_in,
	input wire logic [7:0] op_wdata_in,
	input wire logic [7:0] work_reg_in,
	input wire logic [3:0] bank_select_in,
	input wire logic access_bank_in,
	output logic op_done_out,
	output logic [7:0] op_rdata_out,
	// Direct pointer byte writes and reads
	input wire logic ptr_wr_in,
	input wire logic ptr_wr_high_in,
	input wire logic [1:0] ptr_wr_set_in,
	input wire logic [7:0] ptr_wr_data_in,
	output logic [7:0] pointer_low_byte_out [3],
	output logic [7:0] pointer_high_byte_out [3],
	// Data memory
	output logic mem_en_out,
	output logic mem_we_out,
	output logic [11:0] mem_addr_out,
	output logic [7:0] mem_wdata_out,
	input wire logic [7:0] mem_rdata_in
);
	logic [11:0] ptr_val [3];
	iap_pkg::iap_state_e state;
	iap_pkg::iap_state_e next_state;
	logic [11:0] addr;
	logic [11:0] next_addr;
	logic we;
	logic next_we;
	logic [7:0] wdata;
	logic [7:0] next_wdata;
	logic hit_virtual;
	logic [11:0] target;
	logic [11:0] sel_ptr;
	logic [7:0] rdata;
	logic [7:0] next_rdata;
	logic done;
	logic next_done;
	logic hit_virtual_q;
	logic next_hit_virtual_q;
	logic [1:0] set_eff;

	// ****************************************
	// Pointer pairs
	// ****************************************
	// Set code three falls back to pair zero
	assign set_eff = (op_set_in == 2'h3) ? 2'h0 : op_set_in;
	genvar g;
	generate
		for (g = 0; g < 3; g++)
		begin : g_pair
			iap_ptr_if pif ();
			iap_ptr_pair u_pair (
				.clk_sys_in(clk_sys_in),
				.sys_rst_in(sys_rst_in),
				.ptr_if(pif.pair)
			);
			logic take;
			assign take = op_valid_in && state == iap_pkg::IAP_ST_IDLE
				&& set_eff == 2'(g);
			assign pif.write_hi = ptr_wr_in && ptr_wr_high_in && ptr_wr_set_in == 2'(g);
			assign pif.write_lo = ptr_wr_in && !ptr_wr_high_in && ptr_wr_set_in == 2'(g);
			assign pif.wdata = ptr_wr_data_in;
			assign pif.step_inc = take && (op_mode_in == `IAP_OP_INC_AFTER
				|| op_mode_in == `IAP_OP_INC_BEFORE);
			assign pif.step_dec = take && op_mode_in == `IAP_OP_DEC_AFTER;
			assign ptr_val[g] = pif.value;
			assign pointer_high_byte_out[g] = {4'h0, pif.value[11:8]};
			assign pointer_low_byte_out[g] = pif.value[7:0];
		end
	endgenerate

	// ****************************************
	// Address formation
	// ****************************************
	// bank bits not used
	always_comb
	begin
		sel_ptr = (op_set_in == 2'h1) ? ptr_val[1] :
			(op_set_in == 2'h2) ? ptr_val[2] : ptr_val[0];
		case (op_mode_in)
			`IAP_OP_INC_BEFORE: target = sel_ptr + `IAP_PTR_ONE;
			`IAP_OP_OFFSET: target = sel_ptr + {{4{work_reg_in[7]}}, work_reg_in};
			default: target = sel_ptr;
		endcase
	end

	assign hit_virtual = target >= `IAP_VLOC_BASE && target <= `IAP_VLOC_LAST;

	// ****************************************
	// Access sequencer
	// ****************************************
	always_comb
	begin
		next_state = state;
		next_addr = addr;
		next_we = 1'b0;
		next_wdata = wdata;
		next_rdata = rdata;
		next_done = 1'b0;
		next_hit_virtual_q = hit_virtual_q;
		case (state)
			iap_pkg::IAP_ST_IDLE:
			begin
				next_hit_virtual_q = hit_virtual;
				if (op_valid_in)
				begin
					next_addr = target;
					next_we = op_write_in && !hit_virtual;
					next_wdata = op_wdata_in;
					next_state = iap_pkg::IAP_ST_ACCESS;
				end
			end
			iap_pkg::IAP_ST_ACCESS:
			begin
				next_rdata = hit_virtual_q ? 8'h00 : mem_rdata_in;
				next_done = 1'b1;
				next_state = iap_pkg::IAP_ST_IDLE;
			end
			default: next_state = iap_pkg::IAP_ST_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys_in)
	begin
		if (sys_rst_in)
		begin
			state <= iap_pkg::IAP_ST_IDLE;
			addr <= `IAP_PTR_RESET;
			we <= 1'b0;
			wdata <= 8'h00;
			rdata <= 8'h00;
			done <= 1'b0;
			hit_virtual_q <= 1'b0;
		end
		else
		begin
			state <= next_state;
			addr <= next_addr;
			we <= next_we;
			wdata <= next_wdata;
			rdata <= next_rdata;
			done <= next_done;
			hit_virtual_q <= next_hit_virtual_q;
		end
	end

	assign mem_en_out = state == iap_pkg::IAP_ST_ACCESS && !hit_virtual_q;
	assign mem_we_out = we;
	assign mem_addr_out = addr;
	assign mem_wdata_out = wdata;
	assign op_done_out = done;
	assign op_rdata_out = rdata;

	// ****************************************
	// Checks
	// ****************************************
	property p_done_two;
		@(posedge clk_sys_in) disable iff (sys_rst_in)
		(op_valid_in && state == iap_pkg::IAP_ST_IDLE) |=> ##1 op_done_out;
	endproperty
	a_done_two: assert property (p_done_two) else $error("done not in two cycles");

	property p_plain_keep;
		@(posedge clk_sys_in) disable iff (sys_rst_in)
		(op_valid_in && state == iap_pkg::IAP_ST_IDLE && op_mode_in == `IAP_OP_PLAIN
			&& op_set_in == 2'h0 && !ptr_wr_in) |=> ptr_val[0] == $past(ptr_val[0]);
	endproperty
	a_plain_keep: assert property (p_plain_keep) else $error("plain access moved pointer");

	property p_dec_after;
		@(posedge clk_sys_in) disable iff (sys_rst_in)
		(op_valid_in && state == iap_pkg::IAP_ST_IDLE && op_mode_in == `IAP_OP_DEC_AFTER
			&& op_set_in == 2'h1 && !ptr_wr_in)
			|=> mem_addr_out == $past(ptr_val[1]) && ptr_val[1] == $past(ptr_val[1]) - 12'h001;
	endproperty
	a_dec_after: assert property (p_dec_after) else $error("decrement-after wrong");

	property p_inc_after;
		@(posedge clk_sys_in) disable iff (sys_rst_in)
		(op_valid_in && state == iap_pkg::IAP_ST_IDLE && op_mode_in == `IAP_OP_INC_AFTER
			&& op_set_in == 2'h2 && !ptr_wr_in)
			|=> mem_addr_out == $past(ptr_val[2]) && ptr_val[2] == $past(ptr_val[2]) + 12'h001;
	endproperty
	a_inc_after: assert property (p_inc_after) else $error("increment-after wrong");

	property p_inc_before;
		@(posedge clk_sys_in) disable iff (sys_rst_in)
		(op_valid_in && state == iap_pkg::IAP_ST_IDLE && op_mode_in == `IAP_OP_INC_BEFORE
			&& op_set_in == 2'h0 && !ptr_wr_in) |=> mem_addr_out == ptr_val[0];
	endproperty
	a_inc_before: assert property (p_inc_before) else $error("increment-before wrong");

	property p_offset;
		@(posedge clk_sys_in) disable iff (sys_rst_in)
		(op_valid_in && state == iap_pkg::IAP_ST_IDLE && op_mode_in == `IAP_OP_OFFSET
			&& op_set_in == 2'h0 && !ptr_wr_in)
			|=> mem_addr_out == $past(ptr_val[0]) + {{4{$past(work_reg_in[7])}},
			$past(work_reg_in)} && ptr_val[0] == $past(ptr_val[0]);
	endproperty
	a_offset: assert property (p_offset) else $error("offset access wrong");

	property p_virtual;
		@(posedge clk_sys_in) disable iff (sys_rst_in)
		mem_en_out |-> !(mem_addr_out >= `IAP_VLOC_BASE && mem_addr_out <= `IAP_VLOC_LAST);
	endproperty
	a_virtual: assert property (p_virtual) else $error("virtual location reached");

	property p_high_zero;
		@(posedge clk_sys_in) disable iff (sys_rst_in)
		pointer_high_byte_out[0][7:4] == 4'h0 && pointer_high_byte_out[1][7:4] == 4'h0
			&& pointer_high_byte_out[2][7:4] == 4'h0;
	endproperty
	a_high_zero: assert property (p_high_zero) else $error("upper nibble not zero");

	property p_virtual_quiet;
		@(posedge clk_sys_in) disable iff (sys_rst_in)
		(state == iap_pkg::IAP_ST_ACCESS && hit_virtual_q)
			|-> (!mem_en_out && !mem_we_out) ##1 (op_rdata_out == 8'h00);
	endproperty
	a_virtual_quiet: assert property (p_virtual_quiet) else $error("virtual access not quiet");

	property p_read_data;
		@(posedge clk_sys_in) disable iff (sys_rst_in)
		(state == iap_pkg::IAP_ST_ACCESS && mem_en_out)
			|=> op_done_out && op_rdata_out == $past(mem_rdata_in);
	endproperty
	a_read_data: assert property (p_read_data) else $error("read data not returned");

	property p_done_pulse;
		@(posedge clk_sys_in) disable iff (sys_rst_in)
		op_done_out |=> !op_done_out;
	endproperty
	a_done_pulse: assert property (p_done_pulse) else $error("done longer than one cycle");

	property p_busy_hold;
		@(posedge clk_sys_in) disable iff (sys_rst_in)
		(state == iap_pkg::IAP_ST_ACCESS && !ptr_wr_in) |=> ptr_val[0] == $past(ptr_val[0])
			&& ptr_val[1] == $past(ptr_val[1]) && ptr_val[2] == $past(ptr_val[2]);
	endproperty
	a_busy_hold: assert property (p_busy_hold) else $error("pointer moved while busy");

	property p_carry;
		@(posedge clk_sys_in) disable iff (sys_rst_in)
		(op_valid_in && state == iap_pkg::IAP_ST_IDLE && op_mode_in == `IAP_OP_INC_AFTER
			&& op_set_in == 2'h1 && ptr_val[1][7:0] == 8'hff && !ptr_wr_in)
			|=> ptr_val[1][7:0] == 8'h00 && ptr_val[1][11:8] == $past(ptr_val[1][11:8]) + 4'h1;
	endproperty
	a_carry: assert property (p_carry) else $error("carry into high byte lost");

	property p_write_path;
		@(posedge clk_sys_in) disable iff (sys_rst_in)
		(op_valid_in && state == iap_pkg::IAP_ST_IDLE && op_write_in)
			|=> mem_wdata_out == $past(op_wdata_in) && mem_we_out == mem_en_out;
	endproperty
	a_write_path: assert property (p_write_path) else $error("write strobe or data wrong");

	// ****************************************
	// Scenarios reached
	// ****************************************
	c_inc_after: cover property (@(posedge clk_sys_in) op_valid_in
		&& op_mode_in == `IAP_OP_INC_AFTER);
	c_offset_neg: cover property (@(posedge clk_sys_in) op_valid_in
		&& op_mode_in == `IAP_OP_OFFSET && work_reg_in[7]);
	c_write: cover property (@(posedge clk_sys_in) mem_we_out);
	c_virtual_hit: cover property (@(posedge clk_sys_in)
		state == iap_pkg::IAP_ST_ACCESS && hit_virtual_q);
	c_dec_after: cover property (@(posedge clk_sys_in) op_valid_in
		&& op_mode_in == `IAP_OP_DEC_AFTER);
endmodule : iap_unit

// file: verif/iap_mem_model.sv
// Behavioural data memory on the far side of the unit
`timescale 1ns/1ps
module iap_mem_model (
	// Clock
	input wire logic clk_sys_in,
	// Access from the unit
	input wire logic mem_en_in,
	input wire logic mem_we_in,
	input wire logic [11:0] mem_addr_in,
	input wire logic [7:0] mem_wdata_in,
	output logic [7:0] mem_rdata_out
);
	logic [7:0] mem [4096];
	logic [7:0] junk;
	initial
	begin
		for (int i = 0; i < 4096; i++)
			mem[i] = 8'(i * 7 + 3);
		junk = 8'h3c;
	end
	always @(posedge clk_sys_in)
	begin
		if (mem_en_in && mem_we_in)
			mem[mem_addr_in] <= mem_wdata_in;
		junk <= ~junk;
	end
	// Unselected read bus shows a toggling pattern
	assign mem_rdata_out = mem_en_in ? mem[mem_addr_in] : junk;
endmodule : iap_mem_model

// file: verif/indirect_address_pointers_tb_top.sv
// Self-checking bench for the indirect address pointer unit
`timescale 1ns/1ps
`include "iap_defines.svh"
module indirect_address_pointers_tb_top;
	logic clk_sys_in, sys_rst_in, op_valid_in, op_write_in, access_bank_in;
	logic [1:0] op_set_in, ptr_wr_set_in;
	logic [2:0] op_mode_in;
	logic [7:0] op_wdata_in, work_reg_in, ptr_wr_data_in, op_rdata_out, mem_wdata_out, mem_rdata_in;
	logic [3:0] bank_select_in;
	logic op_done_out, ptr_wr_in, ptr_wr_high_in, mem_en_out, mem_we_out;
	logic [7:0] pointer_low_byte_out [3];
	logic [7:0] pointer_high_byte_out [3];
	logic [11:0] mem_addr_out;
	logic [11:0] ptr [3];
	logic [7:0] shadow [4096];
	logic [8:0] notes [$];
	logic [8:0] nt;
	int error_cnt = 0;
	int comparisons = 0;
	int seed = 72;

	iap_unit iap_unit_i (.clk_sys_in, .sys_rst_in, .op_valid_in, .op_set_in, .op_mode_in,
		.op_write_in, .op_wdata_in, .work_reg_in, .bank_select_in, .access_bank_in, .op_done_out,
		.op_rdata_out, .ptr_wr_in, .ptr_wr_high_in, .ptr_wr_set_in, .ptr_wr_data_in,
		.pointer_low_byte_out, .pointer_high_byte_out, .mem_en_out, .mem_we_out, .mem_addr_out,
		.mem_wdata_out, .mem_rdata_in);
	iap_mem_model iap_mem_model_i (.clk_sys_in, .mem_en_in(mem_en_out), .mem_we_in(mem_we_out),
		.mem_addr_in(mem_addr_out), .mem_wdata_in(mem_wdata_out), .mem_rdata_out(mem_rdata_in));

	initial
	begin
		clk_sys_in = 1'b0;
		forever #2.5 clk_sys_in = ~clk_sys_in;
	end

	// ****************************************
	// Checks and drivers
	// ****************************************
	task automatic chk(string what, logic [11:0] exp, logic [11:0] got);
		comparisons++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic tally_and_finish();
		$display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : tally_and_finish

	task automatic chk_ptrs();
		for (int k = 0; k < 3; k++)
		begin
			chk("ptr_low", {4'h0, ptr[k][7:0]}, {4'h0, pointer_low_byte_out[k]});
			chk("ptr_high", {8'h0, ptr[k][11:8]}, {4'h0, pointer_high_byte_out[k]});
		end
	endtask : chk_ptrs

	task automatic set_ptr(int s, logic [11:0] v);
		for (int h = 1; h >= 0; h--)
		begin
			@(negedge clk_sys_in);
			ptr_wr_in = 1'b1;
			ptr_wr_set_in = 2'(s);
			ptr_wr_high_in = h[0];
			ptr_wr_data_in = h[0] ? {4'h0, v[11:8]} : v[7:0];
			@(negedge clk_sys_in);
			ptr_wr_in = 1'b0;
		end
		ptr[s] = v;
	endtask : set_ptr

	task automatic do_op(int s, int m, bit wr, logic [7:0] wd, logic [7:0] w);
		logic [11:0] a;
		logic [11:0] np;
		bit virt;
		int n;
		a = ptr[s];
		np = a;
		case (m)
			1: np = a - 12'h001;
			2: np = a + 12'h001;
			3:
			begin
				np = a + 12'h001;
				a = np;
			end
			4: a = a + {{4{w[7]}}, w};
			default: np = a;
		endcase
		virt = a >= `IAP_VLOC_BASE && a <= `IAP_VLOC_LAST;
		@(negedge clk_sys_in);
		op_valid_in = 1'b1;
		op_set_in = 2'(s);
		op_mode_in = 3'(m);
		op_write_in = wr;
		op_wdata_in = wd;
		work_reg_in = w;
		bank_select_in = 4'($random(seed));
		access_bank_in = 1'($random(seed));
		@(negedge clk_sys_in);
		op_valid_in = 1'b0;
		chk("mem_en", {11'h0, !virt}, {11'h0, mem_en_out});
		if (!virt)
		begin
			chk("mem_addr", a, mem_addr_out);
			chk("mem_we", {11'h0, wr}, {11'h0, mem_we_out});
			if (wr)
				chk("mem_wdata", {4'h0, wd}, {4'h0, mem_wdata_out});
		end
		notes.push_back(wr ? 9'h000 : {1'b1, virt ? 8'h00 : shadow[a]});
		if (wr && !virt)
			shadow[a] = wd;
		ptr[s] = np;
		n = 0;
		while (op_done_out !== 1'b1 && n < 8)
		begin
			@(negedge clk_sys_in);
			n++;
		end
		chk("done_cycles", 12'h001, 12'(n));
		chk_ptrs();
		if (op_done_out !== 1'b1)
		begin
			error_cnt++;
			tally_and_finish();
		end
	endtask : do_op

	// Read data against the oldest note
	always @(negedge clk_sys_in)
	begin
		if (op_done_out === 1'b1)
		begin
			if (notes.size() == 0)
				chk("note", 12'h001, 12'h000);
			else
			begin
				nt = notes.pop_front();
				if (nt[8])
					chk("op_rdata", {4'h0, nt[7:0]}, {4'h0, op_rdata_out});
			end
		end
	end

	// ****************************************
	// Main sequence
	// ****************************************
	initial
	begin
		{op_valid_in, op_write_in, access_bank_in, op_set_in, op_mode_in} = '0;
		{op_wdata_in, work_reg_in, bank_select_in, ptr_wr_in, ptr_wr_high_in} = '0;
		{ptr_wr_set_in, ptr_wr_data_in} = '0;
		sys_rst_in = 1'b1;
		for (int i = 0; i < 4096; i++)
			shadow[i] = 8'(i * 7 + 3);
		ptr = '{12'h000, 12'h000, 12'h000};
		repeat (16) @(negedge clk_sys_in);
		sys_rst_in = 1'b0;
		chk_ptrs();
		// Every set and every mode, write then read
		for (int s = 0; s < 3; s++)
			for (int m = 0; m < 5; m++)
			begin
				set_ptr(s, 12'($random(seed)));
				do_op(s, m, 1'b1, 8'($random(seed)), 8'($random(seed)));
				do_op(s, m, 1'b0, 8'h00, 8'($random(seed)));
			end
		// Carry, borrow and 12-bit wrap
		set_ptr(1, 12'h0ff);
		do_op(1, 2, 1'b0, 8'h00, 8'h00);
		do_op(1, 1, 1'b0, 8'h00, 8'h00);
		set_ptr(1, 12'hfff);
		do_op(1, 3, 1'b0, 8'h00, 8'h00);
		do_op(1, 1, 1'b0, 8'h00, 8'h00);
		set_ptr(2, 12'h010);
		do_op(2, 4, 1'b0, 8'h00, 8'h80);
		do_op(2, 4, 1'b0, 8'h00, 8'h7f);
		// Virtual locations are not reachable
		set_ptr(0, 12'hfda);
		do_op(0, 3, 1'b1, 8'ha5, 8'h00);
		do_op(0, 0, 1'b0, 8'h00, 8'h00);
		set_ptr(0, `IAP_VLOC_LAST);
		do_op(0, 2, 1'b0, 8'h00, 8'h00);
		repeat (40)
			do_op({$random(seed)} % 3, {$random(seed)} % 5, 1'($random(seed)),
				8'($random(seed)), 8'($random(seed)));
		// Reset in mid-run clears every pointer
		@(negedge clk_sys_in);
		sys_rst_in = 1'b1;
		repeat (2) @(negedge clk_sys_in);
		sys_rst_in = 1'b0;
		ptr = '{12'h000, 12'h000, 12'h000};
		chk_ptrs();
		do_op(2, 3, 1'b0, 8'h00, 8'h00);
		repeat (4) @(negedge clk_sys_in);
		chk("notes_left", 12'h000, 12'(notes.size()));
		tally_and_finish();
	end
endmodule : indirect_address_pointers_tb_top
